// [lcr_defines.vh]
`ifndef LCR_DEFINES_VH
`define LCR_DEFINES_VH

// ***************************************************************
// spi frame layout
// ***************************************************************
`define LCR_FRAME_BITS 5'h10
`define LCR_CMD_MSB 15
`define LCR_CMD_LSB 14
`define LCR_ADDR_MSB 13
`define LCR_ADDR_LSB 9
`define LCR_CMD_WRITE 2'h1
`define LCR_CMD_READ 2'h0

// ***************************************************************
// register addresses
// ***************************************************************
`define LCR_ADDR_CH1 5'h13
`define LCR_ADDR_CH2 5'h14

// ***************************************************************
// config field positions and reset
// ***************************************************************
`define LCR_MODE_MSB 7
`define LCR_MODE_LSB 6
`define LCR_SLEW_MSB 5
`define LCR_SLEW_LSB 4
`define LCR_TERM_BIT 2
`define LCR_EXT_BIT 0
`define LCR_CFG_RESET 8'h00

// ***************************************************************
// mode codes
// ***************************************************************
`define LCR_MODE_OFF 2'h0
`define LCR_MODE_UNUSED 2'h1
`define LCR_MODE_WAKE 2'h2
`define LCR_MODE_TRX 2'h3

// ***************************************************************
// slew codes
// ***************************************************************
`define LCR_SLEW_20K 2'h0
`define LCR_SLEW_10K 2'h1

// ***************************************************************
// pin synchroniser reset levels: cs_b, sclk, mosi, txd2, txd1, low, reg
// ***************************************************************
`define LCR_SYNC_WIDTH 7
`define LCR_SYNC_RESET 7'h5c

`endif

// [lcr_sync.v]
`include "lcr_defines.vh"

module lcr_sync
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // pins
   input wire [`LCR_SYNC_WIDTH-1:0] din,
   // filtered levels
   output reg [`LCR_SYNC_WIDTH-1:0] dout
);

reg [`LCR_SYNC_WIDTH-1:0] s1;
reg [`LCR_SYNC_WIDTH-1:0] s2;
reg [`LCR_SYNC_WIDTH-1:0] s3;
genvar i;
// idle pin levels, so no false edge follows reset
localparam [`LCR_SYNC_WIDTH-1:0] reset_level = `LCR_SYNC_RESET;

// ***************************************************************
// three stages, change taken when stages two and three agree
// ***************************************************************
generate
   for (i = 0; i < `LCR_SYNC_WIDTH; i = i + 1)
   begin : bit_sync
      always @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            s1[i] <= reset_level[i];
            s2[i] <= reset_level[i];
            s3[i] <= reset_level[i];
            dout[i] <= reset_level[i];
         end
         else
         begin
            s1[i] <= din[i];
            s2[i] <= s1[i];
            s3[i] <= s2[i];
            if (s2[i] == s3[i])
            begin
               dout[i] <= s3[i];
            end
         end
      end
   end
endgenerate

endmodule

// [lcr_lin_cfg.v]
// Function
// - second channel mode: off, wake, trx
// - slew field: 20k, 10k, fast
// - bit 2 switches bus termination
// - ext clear: low half-supply forces recessive
// - ext set: run until regulator off
// - trx request refused while txd dominant
// - first channel uses same mode coding
`include "lcr_defines.vh"

module lcr_lin_cfg
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // spi pins
   input wire spi_cs_b,
   input wire spi_sclk,
   input wire spi_mosi,
   output reg spi_miso,
   output reg spi_miso_oe,
   // transceiver status pins
   input wire [1:0] lin_txd,
   input wire half_supply_low,
   input wire transceiver_supply_regulator,
   // per channel controls
   output reg [1:0] lin_trx_enable,
   output reg [1:0] lin_wake_enable,
   output reg [1:0] lin_force_recessive,
   output reg [1:0] lin_slew_fast,
   output reg [1:0] lin_slew_10k,
   output reg [1:0] second_channel_termination_enable_vec
);

wire [`LCR_SYNC_WIDTH-1:0] pin_f;
wire cs_f;
wire sclk_f;
wire mosi_f;
wire [1:0] txd_f;
wire low_f;
wire reg_on_f;
wire [15:0] cfg_flat;
reg sclk_p;
reg cs_p;
reg [15:0] shift_in;
reg [15:0] shift_out;
reg [15:0] reply;
reg [4:0] bit_cnt;
reg wr_stb;
reg [4:0] wr_addr;
reg [7:0] wr_data;
reg [7:0] next_read;
integer k;
genvar i;

// ***************************************************************
// pin synchronisers
// ***************************************************************
lcr_sync u_sync
(
   .clk (clk),
   .rst_b (rst_b),
   .din ({spi_cs_b, spi_sclk, spi_mosi, lin_txd, half_supply_low,
      transceiver_supply_regulator}),
   .dout (pin_f)
);

assign cs_f = pin_f[6];
assign sclk_f = pin_f[5];
assign mosi_f = pin_f[4];
assign txd_f = pin_f[3:2];
assign low_f = pin_f[1];
assign reg_on_f = pin_f[0];

// ***************************************************************
// spi slave, mode 0, msb first
// ***************************************************************
always @(posedge clk or negedge rst_b)
begin
   if (!rst_b)
   begin
      sclk_p <= 1'b0;
      cs_p <= 1'b1;
      shift_in <= 16'h0000;
      shift_out <= 16'h0000;
      bit_cnt <= 5'h00;
      wr_stb <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
   end
   else
   begin
      sclk_p <= sclk_f;
      cs_p <= cs_f;
      wr_stb <= 1'b0;
      spi_miso_oe <= !cs_f;
      if (cs_p && !cs_f)
      begin
         bit_cnt <= 5'h00;
         shift_out <= reply;
         spi_miso <= reply[15];
      end
      else if (!cs_f && !sclk_p && sclk_f)
      begin
         shift_in <= {shift_in[14:0], mosi_f};
         if (bit_cnt != 5'h1f)
         begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
      else if (!cs_f && sclk_p && !sclk_f)
      begin
         shift_out <= {shift_out[14:0], 1'b0};
         spi_miso <= shift_out[14];
      end
      // frames of other lengths are dropped whole
      if (!cs_p && cs_f && bit_cnt == `LCR_FRAME_BITS)
      begin
         wr_stb <= shift_in[`LCR_CMD_MSB:`LCR_CMD_LSB] == `LCR_CMD_WRITE;
         wr_addr <= shift_in[`LCR_ADDR_MSB:`LCR_ADDR_LSB];
         wr_data <= shift_in[7:0];
      end
   end
end

// ***************************************************************
// reply for the next frame: addressed register content
// ***************************************************************
always @*
begin
   next_read = 8'h00;
   if (wr_addr == `LCR_ADDR_CH1)
   begin
      next_read = cfg_flat[7:0];
   end
   else if (wr_addr == `LCR_ADDR_CH2)
   begin
      next_read = cfg_flat[15:8];
   end
end

always @(posedge clk or negedge rst_b)
begin
   if (!rst_b)
   begin
      reply <= 16'h0000;
   end
   else if (!cs_p && cs_f && bit_cnt == `LCR_FRAME_BITS)
   begin
      reply[15:8] <= 8'h00;
   end
   else if (cs_f)
   begin
      reply[7:0] <= next_read;
   end
end

// ***************************************************************
// configuration registers, one per channel
// ***************************************************************
generate
   for (i = 0; i < 2; i = i + 1)
   begin : ch
      reg [7:0] cfg;
      wire [4:0] my_addr;
      wire [1:0] mode_req;
      wire [1:0] mode_new;
      assign my_addr = (i == 0) ? `LCR_ADDR_CH1 : `LCR_ADDR_CH2;
      assign mode_req = wr_data[`LCR_MODE_MSB:`LCR_MODE_LSB];
      assign mode_new = (mode_req == `LCR_MODE_TRX && !txd_f[i]) ?
         cfg[`LCR_MODE_MSB:`LCR_MODE_LSB] : mode_req;
      always @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            cfg <= `LCR_CFG_RESET;
         end
         else if (wr_stb && wr_addr == my_addr)
         begin
            cfg <= {mode_new, wr_data[`LCR_SLEW_MSB:`LCR_SLEW_LSB], 1'b0,
               wr_data[`LCR_TERM_BIT], 1'b0, wr_data[`LCR_EXT_BIT]};
         end
      end
      assign cfg_flat[i*8+7:i*8] = cfg;
   end
endgenerate

// ***************************************************************
// decoded channel controls
// ***************************************************************
always @(posedge clk or negedge rst_b)
begin
   if (!rst_b)
   begin
      lin_trx_enable <= 2'h0;
      lin_wake_enable <= 2'h0;
      lin_force_recessive <= 2'h0;
      lin_slew_fast <= 2'h0;
      lin_slew_10k <= 2'h0;
      second_channel_termination_enable_vec <= 2'h0;
   end
   else
   begin
      for (k = 0; k < 2; k = k + 1)
      begin
         // mode decode; unused code is off
         lin_wake_enable[k] <= cfg_flat[k*8+7 -: 2] == `LCR_MODE_WAKE;
         // low supply and regulator gating
         // regulator off always stops, so ext only covers the low-supply case
         lin_trx_enable[k] <= cfg_flat[k*8+7 -: 2] == `LCR_MODE_TRX &&
            reg_on_f && !(low_f && !cfg_flat[k*8+`LCR_EXT_BIT]);
         lin_force_recessive[k] <= low_f && !cfg_flat[k*8+`LCR_EXT_BIT];
         lin_slew_10k[k] <= cfg_flat[k*8+5 -: 2] == `LCR_SLEW_10K;
         lin_slew_fast[k] <= cfg_flat[k*8+`LCR_SLEW_MSB];
         second_channel_termination_enable_vec[k] <= cfg_flat[k*8+`LCR_TERM_BIT];
      end
   end
end

endmodule

// [lcr_lin_cfg_asserts.sv]
// ***************************************************************
// port checks
// ***************************************************************
module lcr_lin_cfg_asserts
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // pins seen by the block
   input wire spi_cs_b,
   input wire [1:0] lin_txd,
   input wire half_supply_low,
   input wire transceiver_supply_regulator,
   // miso enable and channel controls
   input logic spi_miso_oe,
   input logic [1:0] lin_trx_enable,
   input logic [1:0] lin_wake_enable,
   input logic [1:0] lin_force_recessive,
   input logic [1:0] lin_slew_fast,
   input logic [1:0] lin_slew_10k,
   input logic [1:0] second_channel_termination_enable_vec
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // pins pass 3 sync flops, so causes are held 8 cycles first
   a_mode_exclusive: assert property ((lin_trx_enable & lin_wake_enable) == 2'h0)
      else $error("trx and wake both on");
   a_slew_exclusive: assert property ((lin_slew_fast & lin_slew_10k) == 2'h0)
      else $error("slew fast and 10k both on");
   // a write lands 7 cycles after cs rise, so look one cycle past the idle run
   a_term_idle_stable: assert property (
      spi_cs_b [*8] |=> $stable(second_channel_termination_enable_vec))
      else $error("termination moved without a frame");
   a_force_blocks_trx: assert property ((lin_force_recessive & lin_trx_enable) == 2'h0)
      else $error("trx on while forced recessive");
   a_force_needs_low: assert property (!half_supply_low [*8] |-> lin_force_recessive == 2'h0)
      else $error("forced recessive with supply fine");
   a_reg_off_stops: assert property (!transceiver_supply_regulator [*8] |-> lin_trx_enable == 2'h0)
      else $error("trx on with regulator off");
   a_dominant_refuse: assert property (
      (!lin_txd[1] && transceiver_supply_regulator && !half_supply_low) [*8]
      |-> !$rose(lin_trx_enable[1]))
      else $error("trx entered while txd dominant");
   a_reset_clear: assert property (
      $rose(rst_b) |-> {lin_trx_enable, lin_wake_enable, lin_force_recessive, lin_slew_fast,
      lin_slew_10k, second_channel_termination_enable_vec, spi_miso_oe} == 13'h0000)
      else $error("outputs not clear after reset");
   a_oe_idle_off: assert property (spi_cs_b [*8] |-> !spi_miso_oe) // spi pin enable
      else $error("miso enabled while deselected");
   a_oe_frame_on: assert property (!spi_cs_b [*8] |-> spi_miso_oe) // spi pin enable
      else $error("miso not enabled in frame");
   cover property ($rose(lin_trx_enable[1]));
   cover property ($rose(lin_wake_enable[0]));
   cover property ($rose(lin_force_recessive[1]));
endmodule

bind lcr_lin_cfg lcr_lin_cfg_asserts chk_i (.clk(clk), .rst_b(rst_b), .spi_cs_b(spi_cs_b),
   .lin_txd(lin_txd), .half_supply_low(half_supply_low),
   .transceiver_supply_regulator(transceiver_supply_regulator), .spi_miso_oe(spi_miso_oe),
   .lin_trx_enable(lin_trx_enable), .lin_wake_enable(lin_wake_enable),
   .lin_force_recessive(lin_force_recessive), .lin_slew_fast(lin_slew_fast),
   .lin_slew_10k(lin_slew_10k),
   .second_channel_termination_enable_vec(second_channel_termination_enable_vec));

// [lcr_spi_host.sv]
// ***************************************************************
// host side: spi master and regulator switch
// ***************************************************************
module lcr_spi_host
(
   input wire clk,
   input wire miso,
   output logic cs_b = 1'b1,
   output logic sclk = 1'b0,
   output logic mosi = 1'b0,
   output logic reg_on = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   task power(input logic v);
      @(posedge clk);
      #1 reg_on = v;
   endtask
   // halves kept at 6 and 5 clk, above the 4 clk sclk minimum
   task xfer(input logic [15:0] tx, output logic [15:0] rx);
      @(posedge clk);
      #1 cs_b = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         mosi = tx[i];
         repeat (6) @(posedge clk);
         #1 rx[i] = miso;
         sclk = 1'b1;
         repeat (5) @(posedge clk);
         #1 sclk = 1'b0;
      end
      repeat (2) @(posedge clk);
      #1 cs_b = 1'b1;
      // unselected line shows no stale data
      mosi = ~mosi;
      repeat (8) @(posedge clk);
   endtask
endmodule

// [lcr_lin_cfg_tb.sv]
`include "lcr_defines.vh"
module lcr_lin_cfg_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ***************************************************************
   // bench
   // ***************************************************************
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] lin_txd = 2'h3;
   logic half_supply_low = 1'b0;
   logic [15:0] rx;
   logic [2:0] m;
   wire cs_b, sclk, mosi, miso, miso_oe, reg_on;
   wire [1:0] trx, wake, frc, fast, s10k, term;
   int error_cnt = 0;
   int total_checks = 0;
   always #10 clk = ~clk;
   lcr_lin_cfg uut (.clk(clk), .rst_b(rst_b), .spi_cs_b(cs_b), .spi_sclk(sclk),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .lin_txd(lin_txd),
      .half_supply_low(half_supply_low), .transceiver_supply_regulator(reg_on),
      .lin_trx_enable(trx), .lin_wake_enable(wake), .lin_force_recessive(frc),
      .lin_slew_fast(fast), .lin_slew_10k(s10k), .second_channel_termination_enable_vec(term));
   lcr_spi_host host (.clk(clk), .miso(miso), .cs_b(cs_b), .sclk(sclk), .mosi(mosi),
      .reg_on(reg_on));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      host.xfer({2'h1, a, 1'b0, d}, rx);
   endtask
   // reply comes one frame late
   task rd(input logic [4:0] a, input logic [7:0] e);
      host.xfer({2'h0, a, 9'h000}, rx);
      host.xfer(16'h0000, rx);
      chk(rx, {8'h00, e});
   endtask
   // order trx, wake, force, fast, 10k, term
   task outs(input logic [11:0] e);
      repeat (6) @(posedge clk);
      #1 chk({4'h0, trx, wake, frc, fast, s10k, term}, {4'h0, e});
   endtask
   task close_out;
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #1000000;
      error_cnt++;
      close_out();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (8) @(posedge clk);
      outs(12'h000);
      chk({15'h0000, miso_oe}, 16'h0000);
      rd(`LCR_ADDR_CH2, 8'h00);
      rd(`LCR_ADDR_CH1, 8'h00);
      rd(5'h15, 8'h00);
      host.power(1'b1);
      wr(`LCR_ADDR_CH2, 8'hcf);
      rd(`LCR_ADDR_CH2, 8'hc5);
      outs(12'h802);
      for (m = 3'h0; m < 3'h4; m++)
      begin
         wr(`LCR_ADDR_CH1, {m[1:0], m[1:0], 1'b0, m[0], 2'h0});
         outs({1'b1, m == 3, 1'b0, m == 2, 3'h0, m[1], 1'b0, m == 1, 1'b1, m[0]});
         rd(`LCR_ADDR_CH1, {m[1:0], m[1:0], 1'b0, m[0], 2'h0});
      end
      @(posedge clk);
      #1 half_supply_low = 1'b1;
      outs(12'h853);
      host.power(1'b0);
      outs(12'h053);
      host.power(1'b1);
      outs(12'h853);
      wr(`LCR_ADDR_CH2, 8'hc4);
      outs(12'h0d3);
      @(posedge clk);
      #1 half_supply_low = 1'b0;
      wr(`LCR_ADDR_CH2, 8'h04);
      @(posedge clk);
      #1 lin_txd = 2'h1;
      wr(`LCR_ADDR_CH2, 8'hd4);
      rd(`LCR_ADDR_CH2, 8'h14);
      outs(12'h41b);
      @(posedge clk);
      #1 lin_txd = 2'h3;
      wr(`LCR_ADDR_CH2, 8'hd4);
      rd(`LCR_ADDR_CH2, 8'hd4);
      close_out();
   end
endmodule
